// >>> core/mffc_pkg.sv
// Notes on behaviour
// - preamble up to seven 0x55 octets
// - one 0xD5 delimiter starts the frame
// - six-octet addresses, low byte first
// - length/type: 1536 or more is type
// - frame ends with four-octet CRC
// - no gigabit half-duplex carrier extension
// - VLAN tag 0x8100 plus two info bytes
// - accept tagged frames up to 1522 bytes
// - stacked VLAN adds eight tag bytes
// - crc forward 6, nolen 24, discard 26
// - pause forward 7, ignore 8, xoff 22
// - address insert 9, select bits 16-18
// - half duplex 10, collisions 11, 12
// - soft reset 13, counter clear 31
// - multicast hash choice at bit 14
// - local loopback enable at bit 15
// - magic 19, sleep 20, wakeup 21
// - control frame 23, ten megabit 25
// - tx skip crc 17, tx shift 18
// - rx two-byte shift at bit 25
// - low control bits zero to five
package mffc_pkg;
    // register indices and byte addresses
    localparam logic [7:0] MFFC_IDX_CTRL = 8'h02;
    localparam logic [7:0] MFFC_IDX_TXFC = 8'h3a;
    localparam logic [7:0] MFFC_IDX_RXFC = 8'h3b;
    localparam logic [7:0] MFFC_IDX_STAT = 8'h3c;
    localparam logic [9:0] MFFC_ADDR_CTRL = {MFFC_IDX_CTRL, 2'b00};
    localparam logic [9:0] MFFC_ADDR_TXFC = {MFFC_IDX_TXFC, 2'b00};
    localparam logic [9:0] MFFC_ADDR_RXFC = {MFFC_IDX_RXFC, 2'b00};
    localparam logic [9:0] MFFC_ADDR_STAT = {MFFC_IDX_STAT, 2'b00};
    // control word bit positions
    localparam int MFFC_B_TX_ON = 0;
    localparam int MFFC_B_RX_ON = 1;
    localparam int MFFC_B_XON = 2;
    localparam int MFFC_B_GIG = 3;
    localparam int MFFC_B_ALL_ADDR = 4;
    localparam int MFFC_B_PAD = 5;
    localparam int MFFC_B_CHECK_SEQUENCE_FORWARDING = 6;
    localparam int MFFC_B_FLOW_FWD = 7;
    localparam int MFFC_B_FLOW_IGN = 8;
    localparam int MFFC_B_SRC_INS = 9;
    localparam int MFFC_B_HD_ON = 10;
    localparam int MFFC_B_EXC_COL = 11;
    localparam int MFFC_B_LATE_COL = 12;
    localparam int MFFC_B_SOFT_RST = 13;
    localparam int MFFC_B_MHASH = 14;
    localparam int MFFC_B_LOOP = 15;
    localparam int MFFC_B_SRC_SEL = 16;
    localparam int MFFC_B_MAGIC = 19;
    localparam int MFFC_B_SLEEP = 20;
    localparam int MFFC_B_WAKE = 21;
    localparam int MFFC_B_XOFF = 22;
    localparam int MFFC_B_CTL_FRM = 23;
    localparam int MFFC_B_NO_LEN = 24;
    localparam int MFFC_B_TEN_MB = 25;
    localparam int MFFC_B_ERR_DISC = 26;
    localparam int MFFC_B_CNT_CLR = 31;
    localparam int MFFC_B_TX_SKIP_CRC = 17;
    localparam int MFFC_B_TX_SHIFT = 18;
    localparam int MFFC_B_RX_SHIFT = 25;
    localparam logic [31:0] MFFC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] MFFC_TXFC_RST = 32'h0000_0000;
    localparam logic [31:0] MFFC_RXFC_RST = 32'h0000_0000;
    // writable masks; status-like bits are read only
    localparam logic [31:0] MFFC_CTRL_WMASK = 32'h87ff_e7ff;
    localparam logic [31:0] MFFC_TXFC_WMASK = 32'h0006_0000;
    localparam logic [31:0] MFFC_RXFC_WMASK = 32'h0200_0000;
    // frame constants
    localparam logic [7:0] MFFC_PREAMBLE = 8'h55;
    localparam logic [7:0] MFFC_SFD = 8'hd5;
    localparam logic [3:0] MFFC_PRE_MAX = 4'h7;
    localparam logic [15:0] MFFC_TYPE_MIN = 16'h0600;
    localparam logic [15:0] MFFC_VLAN_TPID = 16'h8100;
    localparam logic [15:0] MFFC_MAX_TAGGED = 16'h05f2;
    localparam logic [15:0] MFFC_MAX_STACKED = 16'h05f6;
    localparam logic [15:0] MFFC_MAX_BASIC = 16'h05ee;
    localparam logic [31:0] MFFC_CRC_POLY = 32'hedb8_8320;
    localparam logic [31:0] MFFC_CRC_INIT = 32'hffff_ffff;
    localparam logic [31:0] MFFC_CRC_RESID = 32'hdebb_20e3;
    localparam logic [3:0] MFFC_ADDR_OCT = 4'h6;
    // register bus request
    typedef struct packed {
        logic [9:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } mffc_bus_t;
    // one received frame verdict
    typedef struct packed {
        logic good;
        logic crc_err;
        logic len_err;
        logic vlan;
        logic stacked;
        logic is_type;
        logic [15:0] len_type;
    } mffc_rxres_t;
endpackage : mffc_pkg

// >>> core/mffc_rx.sv
`timescale 1ns/1ps
// receive frame parser on a GMII-style byte stream, plus registers
module mffc_rx
    import mffc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire mffc_bus_t bus_in,
    output logic [31:0] rdata_out,
    input wire logic [7:0] rxd_in,
    input wire logic rx_dv_in,
    input wire logic rx_er_in,
    output logic [7:0] data_out,
    output logic data_valid_out,
    output logic frame_done_out,
    output mffc_rxres_t result_out,
    output logic [31:0] ctrl_out,
    output logic [31:0] txfc_out,
    output logic [31:0] rxfc_out
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser: three stages, a valid-line change counts when 2 and 3 agree
    logic [9:0] s1_reg, s2_reg, s3_reg, pin_reg;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            s1_reg <= 10'h000;
            s2_reg <= 10'h000;
            s3_reg <= 10'h000;
        end else begin
            s1_reg <= {rx_er_in, rx_dv_in, rxd_in};
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    // bytes change every clock, so only the valid line waits for stages
    // 2 and 3 to agree; data and error follow stage 3 to stay aligned
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pin_reg <= 10'h000;
        end else begin
            pin_reg[7:0] <= s3_reg[7:0];
            pin_reg[9] <= s3_reg[9];
            if (s2_reg[8] == s3_reg[8]) begin
                pin_reg[8] <= s3_reg[8];
            end
        end
    end
    logic [7:0] b;
    logic dv, er;
    assign b = pin_reg[7:0];
    assign dv = pin_reg[8];
    assign er = pin_reg[9];

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic [31:0] ctrl_reg, txfc_reg, rxfc_reg;
    logic [31:0] rdata_reg;
    logic exc_col_reg, late_col_reg;
    logic [15:0] good_cnt_reg, bad_cnt_reg;
    logic soft_rst;
    assign soft_rst = ctrl_reg[MFFC_B_SOFT_RST];

    // control word; soft reset and counter clear self-clear
    // fixed bit map of the word
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            ctrl_reg <= MFFC_CTRL_RST;
        end else if (bus_in.wr && bus_in.addr == MFFC_ADDR_CTRL) begin
            ctrl_reg <= bus_in.wdata & MFFC_CTRL_WMASK;
        end else begin
            ctrl_reg[MFFC_B_SOFT_RST] <= 1'b0;
            ctrl_reg[MFFC_B_CNT_CLR] <= 1'b0;
            if (soft_rst) begin
                // soft reset drops both paths until software re-enables
                ctrl_reg[MFFC_B_TX_ON] <= 1'b0;
                ctrl_reg[MFFC_B_RX_ON] <= 1'b0;
            end
        end
    end
    // frame control registers
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            txfc_reg <= MFFC_TXFC_RST;
            rxfc_reg <= MFFC_RXFC_RST;
        end else if (bus_in.wr) begin
            if (bus_in.addr == MFFC_ADDR_TXFC) begin
                txfc_reg <= bus_in.wdata & MFFC_TXFC_WMASK;
            end
            if (bus_in.addr == MFFC_ADDR_RXFC) begin
                rxfc_reg <= bus_in.wdata & MFFC_RXFC_WMASK;
            end
        end
    end
    // collision indications are fed by half-duplex logic; none here
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            exc_col_reg <= 1'b0;
            late_col_reg <= 1'b0;
        end else begin
            exc_col_reg <= 1'b0;
            late_col_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive parser
    typedef enum {ST_IDLE, ST_PRE, ST_BODY, ST_DROP} mffc_st_t;
    mffc_st_t st_reg;
    logic [3:0] pre_cnt_reg;
    logic [15:0] pos_reg;
    logic [31:0] crc_reg;
    logic [15:0] lt_reg;
    logic vlan_reg, stacked_reg, er_seen_reg;
    logic [31:0] crc_next;
    logic rx_on;
    assign rx_on = ctrl_reg[MFFC_B_RX_ON] && !soft_rst;

    // serial byte update of the reflected CRC-32
    always_comb begin
        crc_next = crc_reg ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++) begin
            crc_next = crc_next[0] ? ((crc_next >> 1) ^ MFFC_CRC_POLY)
                                   : (crc_next >> 1);
        end
    end

    // state: preamble of 0x55, then 0xD5 opens the frame
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            st_reg <= ST_IDLE;
            pre_cnt_reg <= 4'h0;
        end else begin
            case (st_reg)
                ST_IDLE: begin
                    if (dv && rx_on && b == MFFC_PREAMBLE) begin
                        st_reg <= ST_PRE;
                        pre_cnt_reg <= 4'h1;
                    end else if (dv && rx_on) begin
                        st_reg <= ST_DROP;
                    end
                end
                ST_PRE: begin
                    if (!dv) begin
                        st_reg <= ST_IDLE;
                    end else if (b == MFFC_SFD) begin
                        st_reg <= ST_BODY;
                    end else if (b == MFFC_PREAMBLE &&
                                 pre_cnt_reg < MFFC_PRE_MAX) begin
                        pre_cnt_reg <= pre_cnt_reg + 4'h1;
                    end else begin
                        st_reg <= ST_DROP;
                    end
                end
                ST_BODY: begin
                    // no carrier extension: frame ends with dv low
                    if (!dv) begin
                        st_reg <= ST_IDLE;
                    end
                end
                ST_DROP: begin
                    if (!dv) begin
                        st_reg <= ST_IDLE;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // field capture by byte position within the frame
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            pos_reg <= 16'h0000;
            crc_reg <= MFFC_CRC_INIT;
            lt_reg <= 16'h0000;
            vlan_reg <= 1'b0;
            stacked_reg <= 1'b0;
            er_seen_reg <= 1'b0;
        end else if (st_reg != ST_BODY) begin
            pos_reg <= 16'h0000;
            crc_reg <= MFFC_CRC_INIT;
            vlan_reg <= 1'b0;
            stacked_reg <= 1'b0;
            er_seen_reg <= 1'b0;
        end else if (dv) begin
            if (pos_reg != 16'hffff) begin
                pos_reg <= pos_reg + 16'h0001;
            end
            crc_reg <= crc_next;
            if (er) begin
                er_seen_reg <= 1'b1;
            end
            // addresses occupy 0..11, low byte first
            // length/type after them, high byte first
            // later slots only once a tag was seen, else payload
            // bytes would overwrite the client length/type
            if (pos_reg == 16'h000c || (pos_reg == 16'h0010 && vlan_reg) ||
                (pos_reg == 16'h0014 && stacked_reg)) begin
                lt_reg[15:8] <= b;
            end
            if (pos_reg == 16'h000d || (pos_reg == 16'h0011 && vlan_reg) ||
                (pos_reg == 16'h0015 && stacked_reg)) begin
                lt_reg[7:0] <= b;
            end
            // tag recognised: client field sits four bytes later
            if (pos_reg == 16'h000e && lt_reg == MFFC_VLAN_TPID) begin
                vlan_reg <= 1'b1;
            end
            if (pos_reg == 16'h0012 && vlan_reg &&
                lt_reg == MFFC_VLAN_TPID) begin
                stacked_reg <= 1'b1;
            end
        end
    end

    // frame verdict at end of frame
    logic [15:0] max_len;
    logic done_reg, good_reg, crc_err_reg, len_err_reg;
    logic [15:0] res_lt_reg;
    logic res_vlan_reg, res_stk_reg, res_type_reg;
    assign max_len = stacked_reg ? MFFC_MAX_STACKED :
                     vlan_reg ? MFFC_MAX_TAGGED : MFFC_MAX_BASIC;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            done_reg <= 1'b0;
            good_reg <= 1'b0;
            crc_err_reg <= 1'b0;
            len_err_reg <= 1'b0;
            res_lt_reg <= 16'h0000;
            res_vlan_reg <= 1'b0;
            res_stk_reg <= 1'b0;
            res_type_reg <= 1'b0;
        end else begin
            done_reg <= (st_reg == ST_BODY) && !dv;
            if ((st_reg == ST_BODY) && !dv) begin
                crc_err_reg <= (crc_reg != MFFC_CRC_RESID);
                // length check against tag-dependent ceiling
                len_err_reg <= !ctrl_reg[MFFC_B_NO_LEN] &&
                               (pos_reg > max_len || pos_reg < 16'h0012);
                good_reg <= (crc_reg == MFFC_CRC_RESID) && !er_seen_reg &&
                            (ctrl_reg[MFFC_B_NO_LEN] ||
                             (pos_reg <= max_len && pos_reg >= 16'h0012));
                res_lt_reg <= lt_reg;
                res_vlan_reg <= vlan_reg;
                res_stk_reg <= stacked_reg;
                res_type_reg <= (lt_reg >= MFFC_TYPE_MIN);
            end
        end
    end

    // statistics counters, cleared by the counter-clear bit
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            good_cnt_reg <= 16'h0000;
            bad_cnt_reg <= 16'h0000;
        end else if (ctrl_reg[MFFC_B_CNT_CLR] || soft_rst) begin
            good_cnt_reg <= 16'h0000;
            bad_cnt_reg <= 16'h0000;
        end else if (done_reg) begin
            if (good_reg) begin
                good_cnt_reg <= good_cnt_reg + 16'h0001;
            end else begin
                bad_cnt_reg <= bad_cnt_reg + 16'h0001;
            end
        end
    end

    // data stream out; trailing crc held back unless forwarding
    logic [7:0] d1_reg, d2_reg, d3_reg, d4_reg, dout_reg;
    logic dval_reg;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            d1_reg <= 8'h00;
            d2_reg <= 8'h00;
            d3_reg <= 8'h00;
            d4_reg <= 8'h00;
            dout_reg <= 8'h00;
            dval_reg <= 1'b0;
        end else begin
            if (st_reg == ST_BODY && dv) begin
                d1_reg <= b;
                d2_reg <= d1_reg;
                d3_reg <= d2_reg;
                d4_reg <= d3_reg;
            end
            // four-byte delay drops the check sequence
            if (ctrl_reg[MFFC_B_CHECK_SEQUENCE_FORWARDING]) begin
                dout_reg <= b;
                dval_reg <= (st_reg == ST_BODY) && dv;
            end else begin
                dout_reg <= d4_reg;
                dval_reg <= (st_reg == ST_BODY) && dv &&
                            (pos_reg >= 16'h0004);
            end
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                MFFC_ADDR_CTRL: rdata_reg <= ctrl_reg |
                    ({31'h0000_0000, exc_col_reg} << MFFC_B_EXC_COL) |
                    ({31'h0000_0000, late_col_reg} << MFFC_B_LATE_COL);
                MFFC_ADDR_TXFC: rdata_reg <= txfc_reg;
                MFFC_ADDR_RXFC: rdata_reg <= rxfc_reg;
                MFFC_ADDR_STAT: rdata_reg <= {bad_cnt_reg, good_cnt_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign rdata_out = rdata_reg;
    assign data_out = dout_reg;
    assign data_valid_out = dval_reg;
    assign frame_done_out = done_reg;
    assign ctrl_out = ctrl_reg;
    assign txfc_out = txfc_reg;
    assign rxfc_out = rxfc_reg;
    // type when at least 0x600
    assign result_out = '{good: good_reg, crc_err: crc_err_reg,
                          len_err: len_err_reg, vlan: res_vlan_reg,
                          stacked: res_stk_reg,
                          is_type: res_type_reg,
                          len_type: res_lt_reg};

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_sfd_opens;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (st_reg == ST_PRE && dv && b == MFFC_SFD) |=> st_reg == ST_BODY;
    endproperty
    a_sfd_opens: assert property (p_sfd_opens)
        else $error("sfd did not open frame");
    property p_pre_limit;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        st_reg == ST_PRE |-> pre_cnt_reg <= MFFC_PRE_MAX;
    endproperty
    a_pre_limit: assert property (p_pre_limit)
        else $error("preamble too long");
    property p_soft_clear;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (soft_rst && !bus_in.wr) |=> !soft_rst && !ctrl_reg[MFFC_B_RX_ON];
    endproperty
    a_soft_clear: assert property (p_soft_clear)
        else $error("soft reset did not clear");
    property p_cnt_clear;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        ctrl_reg[MFFC_B_CNT_CLR] |=> good_cnt_reg == 16'h0000;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear)
        else $error("counter clear failed");
    property p_ctrl_write;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (bus_in.wr && bus_in.addr == MFFC_ADDR_CTRL) |=>
        ctrl_reg[MFFC_B_LOOP] == $past(bus_in.wdata[MFFC_B_LOOP]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("loopback bit not stored");
    property p_rx_shift;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (bus_in.wr && bus_in.addr == MFFC_ADDR_RXFC) |=>
        rxfc_reg == ($past(bus_in.wdata) & MFFC_RXFC_WMASK);
    endproperty
    a_rx_shift: assert property (p_rx_shift)
        else $error("rx frame control wrong");
    property p_read_lat;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (bus_in.rd && bus_in.addr == MFFC_ADDR_TXFC) |=>
        rdata_reg == txfc_reg;
    endproperty
    a_read_lat: assert property (p_read_lat)
        else $error("tx frame control readback");
    property p_stack_vlan;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        stacked_reg |-> vlan_reg;
    endproperty
    a_stack_vlan: assert property (p_stack_vlan)
        else $error("stacked without vlan");
    property p_done_pulse;
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        done_reg |=> !done_reg;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("frame done held");

endmodule : mffc_rx

// >>> verif/mffc_phy_model.sv
`timescale 1ns/1ps
// line-side stand-in: drives GMII receive bytes into the block
module mffc_phy_model (
    input wire logic clk_sys_in,
    output logic [7:0] rxd_out,
    output logic rx_dv_out,
    output logic rx_er_out
);
    logic busy = 1'b0;
    initial begin
        rxd_out = 8'h3c;
        rx_dv_out = 1'b0;
        rx_er_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // idle data lines keep toggling so a parser that samples them while
    // the valid line is low sees garbage, not a stale byte
    always @(posedge clk_sys_in) begin
        if (!busy) begin
            rxd_out <= ~rxd_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // one frame: pn preamble octets of pb, delimiter, then the body
    task automatic send(input logic [7:0] pb, input int pn, input int er,
                        input logic [7:0] body[$]);
        busy = 1'b1;
        for (int i = 0; i < pn; i++) begin
            @(posedge clk_sys_in);
            rx_dv_out <= 1'b1;
            rxd_out <= pb;
        end
        @(posedge clk_sys_in);
        rxd_out <= 8'hd5;
        foreach (body[i]) begin
            @(posedge clk_sys_in);
            rxd_out <= body[i];
            rx_er_out <= (i == er); // error only where a test asks
        end
        @(posedge clk_sys_in);
        rx_dv_out <= 1'b0;
        rx_er_out <= 1'b0;
        rxd_out <= ~body[body.size() - 1];
        busy = 1'b0;
    endtask : send
endmodule : mffc_phy_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
// self-checking bench for the receive parser and its registers
module tb_top
    import mffc_pkg::*;
;
    logic clk_sys_in;
    logic rst_b_in;
    mffc_bus_t bus;
    logic [31:0] rdata, ctrl, txfc, rxfc, r, ctrl_v;
    logic [7:0] rxd, dout;
    logic rx_dv, rx_er, dval, fdone;
    mffc_rxres_t res, got;
    int bad_count = 0;
    int checked = 0;
    int nframes = 0;
    int good_e = 0;
    int bad_e = 0;
    int seed = 33;
    int tg, pl;
    logic [15:0] lt;
    logic [7:0] cap[$];
    logic [7:0] fr[$];
    int pos[24] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 14, 15, 16, 17, 18,
                    19, 20, 21, 22, 23, 24, 25, 26};
    ////////////////////////////////////////////////////////////////////////
    // clock and instances
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    mffc_rx dut_u (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .bus_in(bus), .rdata_out(rdata), .rxd_in(rxd), .rx_dv_in(rx_dv),
        .rx_er_in(rx_er), .data_out(dout), .data_valid_out(dval),
        .frame_done_out(fdone), .result_out(res), .ctrl_out(ctrl),
        .txfc_out(txfc), .rxfc_out(rxfc));
    mffc_phy_model phy_u (.clk_sys_in(clk_sys_in), .rxd_out(rxd),
        .rx_dv_out(rx_dv), .rx_er_out(rx_er));
    ////////////////////////////////////////////////////////////////////////
    // collect delivered bytes and verdicts; edges see settled registers
    always @(posedge clk_sys_in) begin
        if (dval === 1'b1) cap.push_back(dout);
        if (fdone === 1'b1) begin
            got = res;
            nframes++;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(input logic [31:0] g, input logic [31:0] e,
                       input string m);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        if (a == MFFC_ADDR_CTRL) ctrl_v = d;
        @(posedge clk_sys_in);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys_in);
        bus <= '0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [9:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys_in);
        bus <= '0;
        #1 d = rdata;
    endtask : rd
    // bench's own bitwise CRC, independent of the design's
    function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
        logic [31:0] c;
        c = 32'hffff_ffff;
        foreach (q[i]) begin
            c = c ^ {24'h00_0000, q[i]};
            for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ 32'hedb8_8320
                                                 : c >> 1;
        end
        return ~c;
    endfunction : crc_of
    ////////////////////////////////////////////////////////////////////////
    // build, send and judge one frame; dropped frames must leave no trace
    task automatic frame(input logic [7:0] pb, input int pn, input int t,
                         input int p, input logic [15:0] l, input int er,
                         input bit bad, input bit drop);
        logic [31:0] c;
        logic [7:0] ex[$];
        mffc_rxres_t e;
        bit lerr;
        int n0, miss;
        fr = {};
        repeat (12) fr.push_back(8'($random(seed)));
        repeat (t) begin
            fr.push_back(8'h81);
            fr.push_back(8'h00);
            fr.push_back(8'($random(seed)));
            fr.push_back(8'($random(seed)));
        end
        fr.push_back(l[15:8]);
        fr.push_back(l[7:0]);
        repeat (p) fr.push_back(8'($random(seed)));
        c = crc_of(fr) ^ {31'h0000_0000, bad};
        ex = fr;
        for (int k = 0; k < 4; k++) fr.push_back(c[8*k +: 8]);
        if (ctrl_v[6]) ex = fr;
        cap = {};
        n0 = nframes;
        phy_u.send(pb, pn, er, fr);
        for (int w = 0; w < 60 && nframes == n0; w++) @(posedge clk_sys_in);
        repeat (8) @(posedge clk_sys_in);
        cmp(nframes - n0, drop ? 0 : 1, "frame count");
        if (drop) begin
            cmp(cap.size(), 0, "dropped bytes");
        end else begin
            lerr = !ctrl_v[24] && (fr.size() > 1518 + 4 * t);
            e = '{good: !bad && !lerr && er < 0, crc_err: bad,
                  len_err: lerr, vlan: t > 0, stacked: t == 2,
                  is_type: l >= 16'h0600, len_type: l};
            good_e += e.good;
            bad_e += !e.good;
            cmp({10'h000, got}, {10'h000, e}, "verdict");
            miss = (cap.size() != ex.size());
            foreach (ex[k]) if (k < cap.size() && cap[k] !== ex[k]) miss++;
            cmp(miss, 0, "bytes");
        end
    endtask : frame
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    ////////////////////////////////////////////////////////////////////////
    // a hang counts as a mismatch
    initial begin
        #(4 * 60000);
        bad_count++;
        $display("wrong value at %0t: watchdog expired", $time);
        conclude();
    end
    // main sequence
    initial begin
        ctrl_v = 32'h0000_0000;
        rst_b_in = 1'b0;
        bus = '0;
        repeat (6) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        cmp(ctrl | txfc | rxfc, 0, "reset regs");
        foreach (pos[i]) begin
            wr(MFFC_ADDR_CTRL, 1 << pos[i]);
            rd(MFFC_ADDR_CTRL, r);
            cmp(r, 1 << pos[i], "bit");
            cmp(ctrl, 1 << pos[i], "ctrl");
        end
        wr(MFFC_ADDR_CTRL, 32'h8000_3803);
        rd(MFFC_ADDR_CTRL, r);
        cmp(r, 0, "self clear");
        repeat (8) begin
            wr(MFFC_ADDR_CTRL, $random(seed) & 32'h7fff_dfff);
            rd(MFFC_ADDR_CTRL, r);
            cmp(r, ctrl_v & MFFC_CTRL_WMASK, "random ctrl");
        end
        wr(MFFC_ADDR_TXFC, 32'hffff_ffff);
        rd(MFFC_ADDR_TXFC, r);
        cmp(r, 32'h0006_0000, "txfc");
        wr(MFFC_ADDR_RXFC, 32'hffff_ffff);
        rd(MFFC_ADDR_RXFC, r);
        cmp(r, 32'h0200_0000, "rxfc");
        wr(10'h3fc, 32'hffff_ffff);
        rd(10'h3fc, r);
        cmp(r, 0, "unmapped");
        $display("test registers finished");
        wr(MFFC_ADDR_CTRL, 32'h0000_0000);
        frame(8'h55, 7, 0, 46, 16'h0800, -1, 0, 1);
        wr(MFFC_ADDR_CTRL, 32'h0000_0002);
        for (int n = 1; n <= 7; n++) begin
            frame(8'h55, n, 0, 46, 16'h0800, -1, 0, 0);
        end
        frame(8'h5d, 7, 0, 46, 16'h0800, -1, 0, 1);
        frame(8'h55, 7, 0, 46, 16'h0600, -1, 0, 0);
        frame(8'h55, 7, 0, 1500, 16'h05dc, -1, 0, 0);
        frame(8'h55, 7, 1, 1500, 16'h0800, -1, 0, 0);
        frame(8'h55, 7, 1, 1501, 16'h0800, -1, 0, 0);
        frame(8'h55, 7, 2, 1500, 16'h0800, -1, 0, 0);
        frame(8'h55, 7, 1, 60, 16'h0800, -1, 1, 0);
        frame(8'h55, 7, 0, 60, 16'h0800, 20, 0, 0);
        repeat (6) begin
            tg = ($random(seed) & 3) % 3;
            pl = 46 + ($random(seed) & 127);
            lt = ($random(seed) & 1) ? 16'(pl) : 16'h0600 | 16'($random(seed));
            frame(8'h55, 7, tg, pl, lt, -1, 0, 0);
        end
        wr(MFFC_ADDR_CTRL, 32'h0100_0002);
        frame(8'h55, 7, 1, 1501, 16'h0800, -1, 0, 0);
        wr(MFFC_ADDR_CTRL, 32'h0000_0042);
        frame(8'h55, 7, 0, 50, 16'h0800, -1, 0, 0);
        rd(MFFC_ADDR_STAT, r);
        cmp(r, {bad_e[15:0], good_e[15:0]}, "counts");
        wr(MFFC_ADDR_CTRL, 32'h8000_0002);
        rd(MFFC_ADDR_STAT, r);
        cmp(r, 0, "counts cleared");
        $display("test frames finished");
        conclude();
    end
endmodule : tb_top
